// [rtl/config_word_protection_logic.sv]
// Purpose: Decodes configuration word two and enforces memory protection.
// Assumes: APB slave, one clock, synchronous active-high reset.
// Notes: Programmer and CPU access requests are single-cycle decisions.
// Notes on behaviour
// RULE1: Low-voltage entry refuses programming the low-voltage bit to zero.
// RULE2: Debug bit set frees clock and data pins; clear reserves them.
// RULE3: Low-power brown-out bit one disables it, zero enables it.
// RULE4: Trip select one picks low trip point, zero the high.
// RULE5: Stack-fault bit one makes overflow or underflow reset the device.
// RULE6: Capacitor pin bit one disables capacitor on port A pin 6.
// RULE7: Two-bit field sizes the self-write protected block from 000h.
// RULE8: With 000h-1FFh protected, 200h-7FFh stay self-writable.
// RULE9: Full protection blocks every self-write up to 7FFh.
// RULE10: Self-write permission ignores the code protection bit.
// RULE11: Code protect zero blocks external program access; reads return zero.
// RULE12: Data protect zero blocks external EEPROM reads and writes.
// RULE13: CPU accesses are never affected by code protection.
// RULE14: Program and EEPROM protection use separate, independent bits.
// RULE15: User ID words 8000h-8003h readable and writable while running.
// RULE16: Identity word holds part ID in 13-5, step in 4-0.
// RULE17: Identity word is readable by external tools.
// RULE18: Tools should leave the debug bit at one normally.
// RULE19: Configuration words latched during reset, held while running.
`timescale 1ns/100ps
module config_word_protection_logic
	import cfg_prot_pkg::*;
#(
	parameter logic [8:0] PartId = PartIdDefault,
	parameter logic [4:0] StepId = StepDefault
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [13:0] nvCfgTwo,
	input wire logic [13:0] nvCfgOne,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lowVoltageEntered,
	input wire logic progReq,
	input wire logic progWrite,
	input wire logic progEeprom,
	input wire logic [14:0] progAddr,
	input wire logic [13:0] progWdata,
	input wire logic [13:0] memRdata,
	output logic progGrant,
	output logic [13:0] progRdata,
	output logic progRdValid,
	input wire logic cpuWriteReq,
	input wire logic [14:0] cpuWriteAddr,
	output logic cpuWriteGrant,
	input wire logic stackFault,
	output logic stackReset,
	output logic debugPinsOwned,
	output logic lowPowerBorOn,
	output logic lowTripSelected,
	output logic capPinOn
);
	cfg_word_if cfg ();
	logic [13:0] userId [4];
	logic [1:0] refusedReg;
	logic [31:0] prdataNext;
	logic swAllowed;
	logic apbWrite;
	logic apbRead;
	logic progPmAllowed;
	logic progEeAllowed;
	logic progAllowed;
	logic lvBitRefused;
	logic progUserHit;
	logic progIdentHit;
	logic [13:0] progRdNext;
	logic [13:0] identityWord;
	logic [1:0] userIdx;
	logic [1:0] progUserIdx;
	logic addrMapped;
	logic isUserIdAddr;

	cfg_word_loader loader (
		.clk(clk),
		.sys_rst(sys_rst),
		.nvCfgTwo(nvCfgTwo),
		.nvCfgOne(nvCfgOne),
		.cfg(cfg)
	);

	self_write_check self_write_check_i (
		.wrtField(cfg.cfgTwo[WriteProtLsb +: 2]),
		.addr(cpuWriteAddr),
		.allowed(swAllowed)
	);

	// RULE16 identity layout.
	// Identity word packs the part and step fields.
	assign identityWord = {PartId, StepId};

	// APB decode; the bus answers with no wait states.
	assign apbWrite = psel && penable && pwrite;
	assign apbRead = psel && !pwrite;
	assign isUserIdAddr = paddr >= OffUserId0 && paddr < OffRefused && paddr[1:0] == 2'h0;
	assign userIdx = paddr[3:2];
	assign addrMapped = isUserIdAddr || paddr == OffCfgTwo || paddr == OffCfgOne || paddr == OffIdentity
		|| paddr == OffStatus || paddr == OffRefused;

	// Read data selection for the APB window.
	always_comb
	begin
		prdataNext = 32'h0000_0000;
		if (isUserIdAddr)
			prdataNext = {18'h00000, userId[userIdx]};
		else if (paddr == OffCfgTwo)
			prdataNext = {18'h00000, cfg.cfgTwo};
		else if (paddr == OffCfgOne)
			prdataNext = {18'h00000, cfg.cfgOne};
		else if (paddr == OffIdentity)
			prdataNext = {18'h00000, identityWord};
		else if (paddr == OffStatus)
			prdataNext = {26'h0000000, debugPinsOwned, lowPowerBorOn, lowTripSelected, capPinOn,
				stackReset, cpuWriteGrant};
		else if (paddr == OffRefused)
			prdataNext = {30'h00000000, refusedReg};
	end

	// APB outputs are registered; the answer comes in the access phase.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addrMapped;
			prdata <= (psel && !penable && apbRead) ? prdataNext : 32'h0000_0000;
		end
	end

	// Programmer request decode.
	assign progUserHit = progAddr >= UserIdBase && progAddr <= UserIdLast;
	assign progIdentHit = progAddr == IdentityAddr;
	assign progUserIdx = progAddr[1:0];
	// RULE11 program memory gate.
	assign progPmAllowed = cfg.cfgOne[CodeProtBit];
	// RULE12 EEPROM gate, RULE14 independent bits.
	assign progEeAllowed = cfg.cfgOne[DataProtBit];
	// RULE1 refuse clearing the low-voltage bit.
	assign lvBitRefused = progWrite && !progEeprom && lowVoltageEntered && progAddr == UserIdBase + 15'h0007
		&& !progWdata[LowVoltageBit];
	assign progAllowed = progEeprom ? progEeAllowed : (progUserHit || progIdentHit || progPmAllowed);

	// RULE11 zeros on protected read, RULE17 identity readable.
	always_comb
	begin
		progRdNext = 14'h0000;
		if (progEeprom)
			progRdNext = progEeAllowed ? memRdata : 14'h0000;
		else if (progIdentHit)
			progRdNext = identityWord;
		else if (progUserHit)
			progRdNext = userId[progUserIdx];
		else if (progPmAllowed)
			progRdNext = memRdata;
	end

	// User ID storage, writable from the bus and the programmer.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 4; i++)
				userId[i] <= CfgErased;
		end
		// RULE15 user ID writes.
		else if (apbWrite && isUserIdAddr)
			userId[userIdx] <= pwdata[13:0];
		else if (progReq && progWrite && progUserHit && !progEeprom)
			userId[progUserIdx] <= progWdata;
	end

	// Programmer and CPU answers, one cycle after the request.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			progGrant <= 1'b0;
			progRdata <= 14'h0000;
			progRdValid <= 1'b0;
			cpuWriteGrant <= 1'b0;
			refusedReg <= 2'h0;
		end
		else
		begin
			progGrant <= progReq && cfg.valid && progAllowed && !lvBitRefused;
			progRdValid <= progReq && !progWrite;
			progRdata <= (progReq && !progWrite) ? progRdNext : 14'h0000;
			// RULE13 CPU unaffected by code protection.
			cpuWriteGrant <= cpuWriteReq && cfg.valid && swAllowed;
			// Set wins over a clear written in the same cycle.
			refusedReg[0] <= (progReq && (!progAllowed || lvBitRefused))
				|| (refusedReg[0] && !(apbWrite && paddr == OffRefused && pwdata[0]));
			refusedReg[1] <= (cpuWriteReq && !swAllowed)
				|| (refusedReg[1] && !(apbWrite && paddr == OffRefused && pwdata[1]));
		end
	end

	// Decoded configuration controls.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stackReset <= 1'b0;
			debugPinsOwned <= 1'b0;
			lowPowerBorOn <= 1'b0;
			lowTripSelected <= 1'b1;
			capPinOn <= 1'b0;
		end
		else
		begin
			// RULE5 stack fault reset.
			stackReset <= stackFault && cfg.cfgTwo[StackResetBit];
			// RULE2 debugger pin ownership.
			debugPinsOwned <= !cfg.cfgTwo[DebugBit];
			// RULE3 low-power brown-out enable.
			lowPowerBorOn <= !cfg.cfgTwo[LowPowerBorBit];
			// RULE4 trip point select.
			lowTripSelected <= cfg.cfgTwo[TripSelectBit];
			// RULE6 capacitor pin function.
			capPinOn <= !cfg.cfgTwo[CapPinBit];
		end
	end

	// Request shapes shared by the checks below.
	sequence pmReadReq;
		progReq && !progWrite && !progEeprom && !progUserHit && !progIdentHit;
	endsequence : pmReadReq
	sequence cpuLiveReq;
		cfg.valid && cpuWriteReq;
	endsequence : cpuLiveReq
	// RULE1 refused clear.
	lv_refuse_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
		progReq && lvBitRefused |=> !progGrant)
		else $error("Low-voltage bit clear was granted.");
	// RULE1 refusal flagged.
	lv_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
		progReq && lvBitRefused |=> refusedReg[0])
		else $error("Refused programmer access not flagged.");
	// RULE2 pins.
	debug_pins_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
		$past(!sys_rst) |-> debugPinsOwned == !$past(cfg.cfgTwo[DebugBit]))
		else $error("Debugger pin ownership wrong.");
	// RULE3 low-power brown-out.
	lp_bor_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
		$past(!sys_rst) |-> lowPowerBorOn != $past(cfg.cfgTwo[LowPowerBorBit]))
		else $error("Low-power brown-out enable wrong.");
	// RULE4 trip point.
	trip_select_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
		$past(!sys_rst) |-> lowTripSelected == $past(cfg.cfgTwo[TripSelectBit]))
		else $error("Brown-out trip select wrong.");
	// RULE5 stack fault.
	stack_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
		stackFault && cfg.cfgTwo[StackResetBit] |=> stackReset)
		else $error("Stack fault did not reset.");
	// RULE5 no stray reset.
	stack_quiet_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
		!(stackFault && cfg.cfgTwo[StackResetBit]) |=> !stackReset)
		else $error("Stack reset without enabled fault.");
	// RULE6 capacitor pin.
	cap_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		$past(!sys_rst) |-> capPinOn != $past(cfg.cfgTwo[CapPinBit]))
		else $error("Capacitor pin function wrong.");
	// RULE7 low block shielded.
	low_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		cpuWriteReq && cfg.cfgTwo[1:0] != WrtOff && cpuWriteAddr <= QuarterEnd |=> !cpuWriteGrant)
		else $error("Self-write granted inside lowest block.");
	// RULE7 half block shielded.
	half_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		cpuWriteReq && cfg.cfgTwo[1:0] == WrtHalf && cpuWriteAddr <= HalfEnd |=> !cpuWriteGrant)
		else $error("Self-write granted inside half block.");
	// RULE9 full protection.
	full_prot_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
		cpuWriteReq && cfg.cfgTwo[1:0] == WrtAll |=> !cpuWriteGrant)
		else $error("Self-write granted under full protection.");
	// RULE9 refusal flagged.
	wrt_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
		cpuWriteReq && !swAllowed |=> refusedReg[1])
		else $error("Refused self-write not flagged.");
	// RULE8 upper area.
	upper_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
		cfg.valid && cpuWriteReq && cfg.cfgTwo[1:0] == WrtQuarter && cpuWriteAddr >= 15'h0200
		&& cpuWriteAddr <= AllEnd |=> cpuWriteGrant)
		else $error("Self-write above protected block refused.");
	// RULE10 code protect ignored.
	wrt_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
		cpuLiveReq ##0 (cfg.cfgTwo[1:0] == WrtOff) |=> cpuWriteGrant)
		else $error("Unprotected self-write refused.");
	// RULE11 zero read.
	code_prot_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
		progReq && !progWrite && !progEeprom && !progUserHit && !progIdentHit && !cfg.cfgOne[CodeProtBit]
		|=> progRdValid && progRdata == 14'h0000 && !progGrant)
		else $error("Protected program memory read leaked.");
	// RULE11 open read passes.
	pm_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
		pmReadReq ##0 cfg.cfgOne[CodeProtBit] |=> progRdata == $past(memRdata))
		else $error("Open program memory read lost data.");
	// RULE11 open program access.
	pm_open_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
		cfg.valid && progReq && !progEeprom && cfg.cfgOne[CodeProtBit] && !lvBitRefused |=> progGrant)
		else $error("Open program memory access refused.");
	// RULE12 EEPROM gate.
	data_prot_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
		progReq && progEeprom && !cfg.cfgOne[DataProtBit] |=> !progGrant && progRdata == 14'h0000)
		else $error("Protected EEPROM access passed.");
	// RULE14 EEPROM open alone.
	ee_open_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
		cfg.valid && progReq && progEeprom && cfg.cfgOne[DataProtBit] |=> progGrant)
		else $error("Open EEPROM access refused.");
	// RULE15 user words open.
	user_open_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
		cfg.valid && progReq && !progEeprom && progUserHit |=> progGrant)
		else $error("User word access refused.");
	// RULE15 bus answer.
	apb_answer_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
		psel && !penable |=> pready && pslverr == !$past(addrMapped))
		else $error("Register bus answer wrong.");
	// RULE17 identity read.
	ident_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
		progReq && !progWrite && progIdentHit && !progEeprom |=> progRdata == identityWord)
		else $error("Identity word not returned.");
	// RULE17 read data marked.
	rd_valid_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
		progReq && !progWrite |=> progRdValid)
		else $error("Programmer read not marked valid.");
endmodule : config_word_protection_logic

// [include/cfg_prot_pkg.sv]
// Purpose: Shared constants for the configuration word protection block.
// Assumes: 14-bit configuration words, APB register window with 32-bit data.
// Notes: Bit positions follow configuration words two and one; unused bits read back as stored.
package cfg_prot_pkg;

	// Field positions in configuration word two.
	localparam int LowVoltageBit = 13;
	localparam int DebugBit = 12;
	localparam int LowPowerBorBit = 11;
	localparam int TripSelectBit = 10;
	localparam int StackResetBit = 9;
	localparam int CapPinBit = 5;
	localparam int WriteProtLsb = 0;
	// Field positions in configuration word one used here.
	localparam int DataProtBit = 8;
	localparam int CodeProtBit = 7;
	// Erased value of a configuration word.
	localparam logic [13:0] CfgErased = 14'h3fff;
	// Identity word layout.
	localparam int PartIdLsb = 5;
	localparam int StepLsb = 0;
	// Arbitrary neutral identity values.
	localparam logic [8:0] PartIdDefault = 9'h0a5;
	localparam logic [4:0] StepDefault = 5'h01;

	// Self-write protection encodings.
	localparam logic [1:0] WrtOff = 2'h3;
	localparam logic [1:0] WrtQuarter = 2'h2;
	localparam logic [1:0] WrtHalf = 2'h1;
	localparam logic [1:0] WrtAll = 2'h0;
	// Protected block ends, last protected address.
	localparam logic [14:0] QuarterEnd = 15'h01ff;
	localparam logic [14:0] HalfEnd = 15'h03ff;
	localparam logic [14:0] AllEnd = 15'h07ff;

	// Configuration space addresses.
	localparam logic [14:0] UserIdFirst = 15'h0000;
	localparam logic [14:0] UserIdBase = 15'h8000;
	localparam logic [14:0] UserIdLast = 15'h8003;
	localparam logic [14:0] IdentityAddr = 15'h8006;

	// APB register byte offsets.
	localparam logic [7:0] OffCfgTwo = 8'h00;
	localparam logic [7:0] OffCfgOne = 8'h04;
	localparam logic [7:0] OffIdentity = 8'h08;
	localparam logic [7:0] OffStatus = 8'h0c;
	localparam logic [7:0] OffUserId0 = 8'h10;
	localparam logic [7:0] OffRefused = 8'h20;

	// Latching phase of the configuration loader.
	typedef enum logic [1:0] {LoadIdle, LoadWait, LoadDone} load_state_t;

endpackage : cfg_prot_pkg

// [include/cfg_word_if.sv]
// Purpose: Carries the decoded configuration word between the modules.
// Assumes: Driven by the loader, read by the checker.
// Notes: Values stay constant between resets.
`timescale 1ns/100ps
interface cfg_word_if;
	logic [13:0] cfgTwo;
	logic [13:0] cfgOne;
	logic valid;
	modport source (output cfgTwo, output cfgOne, output valid);
	modport sink (input cfgTwo, input cfgOne, input valid);
endinterface : cfg_word_if

// [rtl/cfg_word_loader.sv]
// Purpose: Latches the nonvolatile configuration words while reset is held.
// Assumes: Nonvolatile outputs are stable, from the same clock domain.
// Notes: Words are taken every cycle of reset and then held.
`timescale 1ns/100ps
module cfg_word_loader
	import cfg_prot_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [13:0] nvCfgTwo,
	input wire logic [13:0] nvCfgOne,
	cfg_word_if.source cfg
);
	logic [13:0] twoReg;
	logic [13:0] oneReg;
	logic validReg;

	// RULE19 latch during reset.
	// Words track storage while reset is held and freeze at release.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			twoReg <= nvCfgTwo;
			oneReg <= nvCfgOne;
		end
		validReg <= !sys_rst;
	end

	assign cfg.cfgTwo = twoReg;
	assign cfg.cfgOne = oneReg;
	assign cfg.valid = validReg;

	// RULE19 held while running.
	cfg_held_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
		validReg && $past(validReg) |-> $stable(twoReg) && $stable(oneReg))
		else $error("Configuration word changed while running.");
endmodule : cfg_word_loader

// [rtl/self_write_check.sv]
// Purpose: Decides whether a CPU self-write to program memory is allowed.
// Assumes: Address is a program memory word address.
// Notes: Pure decode; the code protection bit is deliberately not an input.
`timescale 1ns/100ps
module self_write_check
	import cfg_prot_pkg::*;
(
	input wire logic [1:0] wrtField,
	input wire logic [14:0] addr,
	output logic allowed
);
	logic [14:0] lastProt;
	logic protAny;

	// RULE7 block size select.
	assign protAny = (wrtField != WrtOff);
	assign lastProt = (wrtField == WrtQuarter) ? QuarterEnd : (wrtField == WrtHalf) ? HalfEnd : AllEnd;
	// RULE8 upper area writable, RULE9 all blocked, RULE10 no code protect term.
	assign allowed = !protAny || (wrtField != WrtAll && addr > lastProt && addr <= AllEnd);
endmodule : self_write_check

// [sim/prog_tool_model.sv]
// Purpose: Stand-in for the external programmer and the memory behind it.
// Assumes: Requests start just after a rising edge and last one cycle.
// Notes: Idle memory data flips every cycle so stale values never match.
`timescale 1ns/100ps
module prog_tool_model
(
	input wire logic clk,
	output logic progReq,
	output logic progWrite,
	output logic progEeprom,
	output logic [14:0] progAddr,
	output logic [13:0] progWdata,
	output logic [13:0] memRdata
);
	logic [13:0] idlePat = 14'h1555;
	initial
	begin
		progReq = 1'b0;
		progWrite = 1'b0;
		progEeprom = 1'b0;
		progAddr = 15'h0;
		progWdata = 14'h0;
	end
	// Memory answers with an address pattern, otherwise a toggling value.
	always @(posedge clk) idlePat <= ~idlePat;
	assign memRdata = progReq ? (progAddr[13:0] ^ 14'h0a5a) : idlePat;
	// identity reads, debug bit
	// One request cycle; address and write data are inverted once it is released.
	task automatic access(input logic wr, input logic ee, input logic [14:0] a, input logic [13:0] d);
	begin
		@(posedge clk);
		progReq <= 1'b1;
		progWrite <= wr;
		progEeprom <= ee;
		progAddr <= a;
		progWdata <= d;
		@(posedge clk);
		progReq <= 1'b0;
		progAddr <= ~a;
		progWdata <= ~d;
	end
	endtask : access
endmodule : prog_tool_model

// [sim/tb.sv]
// Purpose: Self-checking bench for the configuration protection block.
// Assumes: APB answers in the access phase; grants come one cycle later.
// Notes: Each configuration is applied through a fresh reset.
`timescale 1ns/100ps
module tb
	import cfg_prot_pkg::*;
;
	logic clk, sys_rst, psel, penable, pwrite, lowVoltageEntered, cpuWriteReq, stackFault;
	logic pready, pslverr, progReq, progWrite, progEeprom, progGrant, progRdValid, cpuWriteGrant;
	logic stackReset, debugPinsOwned, lowPowerBorOn, lowTripSelected, capPinOn, bad;
	logic [13:0] nvCfgTwo, nvCfgOne, progWdata, memRdata, progRdata;
	logic [14:0] progAddr, cpuWriteAddr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int num_errors = 0;
	int compares = 0;
	config_word_protection_logic config_word_protection_logic_i (.clk, .sys_rst, .nvCfgTwo, .nvCfgOne,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lowVoltageEntered, .progReq,
		.progWrite, .progEeprom, .progAddr, .progWdata, .memRdata, .progGrant, .progRdata, .progRdValid,
		.cpuWriteReq, .cpuWriteAddr, .cpuWriteGrant, .stackFault, .stackReset, .debugPinsOwned,
		.lowPowerBorOn, .lowTripSelected, .capPinOn);
	prog_tool_model prog_tool_model_i (.clk, .progReq, .progWrite, .progEeprom, .progAddr, .progWdata,
		.memRdata);
	// Free-running system clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
	begin
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask : tally_and_finish
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
	begin
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
	begin
		chk_word({31'h0, got}, {31'h0, exp});
	end
	endtask : chk_bit
	// Loads new configuration words under a two-cycle reset.
	task automatic restart(input logic [13:0] two, input logic [13:0] one);
	begin
		@(posedge clk);
		nvCfgTwo <= two;
		nvCfgOne <= one;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
	end
	endtask : restart
	// One APB transfer; read data lands in rd, the error flag in bad.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
	begin
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			num_errors++;
			$display("mismatch at %0t: bus wait ran out", $time);
			tally_and_finish();
		end
		rd = prdata;
		bad = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask : apb
	task automatic cpu_try(input logic [14:0] a, input logic exp);
	begin
		@(posedge clk);
		cpuWriteReq <= 1'b1;
		cpuWriteAddr <= a;
		@(posedge clk);
		cpuWriteReq <= 1'b0;
		#1 chk_bit(cpuWriteGrant, exp);
	end
	endtask : cpu_try
	task automatic prog(input logic wr, input logic ee, input logic [14:0] a, input logic [13:0] d,
		input logic eg, input logic [13:0] er);
	begin
		prog_tool_model_i.access(wr, ee, a, d);
		#1 chk_bit(progGrant, eg);
		chk_bit(progRdValid, !wr);
		if (!wr)
			chk_word({18'h0, progRdata}, {18'h0, er});
	end
	endtask : prog
	// A change of the stored words while running, then the pin and reset decode checks.
	task automatic sc_decode(input logic [13:0] two);
	begin
		restart(two, CfgErased);
		nvCfgTwo <= ~two;
		@(posedge clk);
		stackFault <= 1'b1;
		@(posedge clk);
		stackFault <= 1'b0;
		#1 chk_bit(stackReset, two[StackResetBit]);
		chk_bit(debugPinsOwned, !two[DebugBit]);
		chk_bit(lowPowerBorOn, !two[LowPowerBorBit]);
		chk_bit(lowTripSelected, two[TripSelectBit]);
		chk_bit(capPinOn, !two[CapPinBit]);
		apb(1'b0, OffCfgTwo, 32'h0);
		chk_word(rd, {18'h0, two});
		apb(1'b0, OffStatus, 32'h0);
		chk_word(rd, {26'h0, !two[DebugBit], !two[LowPowerBorBit], two[TripSelectBit], !two[CapPinBit], 2'h0});
	end
	endtask : sc_decode
	// Self-write grants at the edges of every protected block.
	task automatic sc_wrt(input logic [1:0] w, input logic [13:0] one);
		logic [14:0] adr [6] = '{15'h0, 15'h1ff, 15'h200, 15'h3ff, 15'h400, 15'h7ff};
		logic [14:0] lim;
	begin
		lim = (w == 2'h2) ? 15'h1ff : (w == 2'h1) ? 15'h3ff : 15'h7ff;
		restart({12'hfff, w}, one);
		foreach (adr[i])
			cpu_try(adr[i], w == 2'h3 || adr[i] > lim);
	end
	endtask : sc_wrt
	// External access against both protection bits.
	task automatic sc_ext(input logic [13:0] one);
		logic cp, cd;
	begin
		cp = one[CodeProtBit];
		cd = one[DataProtBit];
		restart(CfgErased, one);
		prog(1'b0, 1'b0, 15'h0123, 14'h0, cp, cp ? 14'h0b79 : 14'h0);
		prog(1'b1, 1'b0, 15'h0124, 14'h1234, cp, 14'h0);
		prog(1'b0, 1'b1, 15'h0010, 14'h0, cd, cd ? 14'h0a4a : 14'h0);
		prog(1'b1, 1'b1, 15'h0011, 14'h0055, cd, 14'h0);
		prog(1'b0, 1'b0, IdentityAddr, 14'h0, 1'b1, {PartIdDefault, StepDefault});
		prog(1'b0, 1'b0, UserIdBase + 15'h0001, 14'h0, 1'b1, CfgErased);
		cpu_try(15'h0500, 1'b1);
	end
	endtask : sc_ext
	// Low-voltage bit writes with and without low-voltage entry.
	task automatic sc_lowv();
	begin
		restart(CfgErased, CfgErased);
		lowVoltageEntered <= 1'b1;
		prog(1'b1, 1'b0, 15'h8007, 14'h1fff, 1'b0, 14'h0);
		prog(1'b1, 1'b0, 15'h8007, 14'h3fff, 1'b1, 14'h0);
		@(posedge clk);
		lowVoltageEntered <= 1'b0;
		prog(1'b1, 1'b0, 15'h8007, 14'h1fff, 1'b1, 14'h0);
		apb(1'b0, OffRefused, 32'h0);
		chk_word(rd, 32'h1);
		apb(1'b1, OffRefused, 32'h1);
		apb(1'b0, OffRefused, 32'h0);
		chk_word(rd, 32'h0);
	end
	endtask : sc_lowv
	// User words, identity and an unmapped offset over the register bus.
	task automatic sc_regs();
	begin
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, OffUserId0 + 8'(4 * i), 32'h0);
			chk_word(rd, 32'h3fff);
			apb(1'b1, OffUserId0 + 8'(4 * i), 32'h0120 + 32'(i));
		end
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, OffUserId0 + 8'(4 * i), 32'h0);
			chk_word(rd, 32'h0120 + 32'(i));
		end
		apb(1'b0, OffIdentity, 32'h0);
		chk_word(rd, {18'h0, PartIdDefault, StepDefault});
		chk_bit(bad, 1'b0);
		apb(1'b0, 8'h24, 32'h0);
		chk_bit(bad, 1'b1);
	end
	endtask : sc_regs
	// Main sequence.
	initial
	begin
		{sys_rst, psel, penable, pwrite, lowVoltageEntered, cpuWriteReq, stackFault} = 7'h40;
		{nvCfgTwo, nvCfgOne, paddr, pwdata, cpuWriteAddr} = '0;
		sc_decode(14'h3fff);
		sc_decode(14'h21df);
		sc_wrt(2'h3, 14'h3fff);
		sc_wrt(2'h2, 14'h3f7f);
		sc_wrt(2'h1, 14'h3fff);
		sc_wrt(2'h0, 14'h3f7f);
		sc_ext(14'h3fff);
		sc_ext(14'h3f7f);
		sc_ext(14'h3eff);
		sc_ext(14'h3e7f);
		sc_lowv();
		sc_regs();
		tally_and_finish();
	end
	// Cuts a hang short.
	initial
	begin
		#500000;
		num_errors++;
		$display("mismatch at %0t: run limit reached", $time);
		tally_and_finish();
	end
endmodule : tb
